// ==== design/lpcp_pkg.sv ====
// shared constants and types for the line printer control port
package lpcp_pkg;
   // controller clock and mechanism times
   localparam int CLK_MHZ  = 200;
   localparam int SPACE_NS = 20000;
   localparam int PRINT_NS = 20000;
   localparam int EJECT_NS = 20000;
   localparam int SPACE_CYC = (SPACE_NS * CLK_MHZ + 999) / 1000;
   localparam int PRINT_CYC = (PRINT_NS * CLK_MHZ + 999) / 1000;
   localparam int EJECT_CYC = (EJECT_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W = 13;
   localparam logic [TMR_W-1:0] SPACE_LD = TMR_W'(SPACE_CYC);
   localparam logic [TMR_W-1:0] PRINT_LD = TMR_W'(PRINT_CYC);
   localparam logic [TMR_W-1:0] EJECT_LD = TMR_W'(EJECT_CYC);

   // line buffer
   localparam int CNT_W = 7;
   localparam int LINE_WORDS = 68;
   localparam logic [CNT_W-1:0] LINE_FULL = 7'h44;
   localparam logic [7:0] ILLEGAL_CHAR = 8'h00;
   localparam logic [3:0] TOF_LEVEL = 4'h1;

   // register port word addresses
   localparam logic [1:0] A_DATA = 2'h0;
   localparam logic [1:0] A_FUNC = 2'h1;
   localparam logic [1:0] A_EVT  = 2'h2;
   localparam logic [1:0] A_MASK = 2'h3;

   // status word bit positions
   localparam int ST_READY = 0;
   localparam int ST_BUSY  = 1;
   localparam int ST_INT   = 2;
   localparam int ST_DATA  = 3;
   localparam int ST_EOP   = 4;
   localparam int ST_ALARM = 5;
   localparam int ST_PROT  = 7;
   localparam int ST_TOF   = 9;

   // interrupt select order inside sel vector
   localparam int SEL_DATA  = 0;
   localparam int SEL_EOP   = 1;
   localparam int SEL_ALARM = 2;

   typedef struct packed {
      logic [3:0] fmt_level;
      logic [3:0] rsvd;
      logic       fmt_sel;
      logic       print;
      logic       space;
      logic       alarm_sel;
      logic       eop_sel;
      logic       data_sel;
      logic       clr_int;
      logic       clr_prn;
   } lpcp_cmd_s;

   typedef struct packed {
      logic reject;
      logic alarm;
      logic eop;
      logic data;
   } lpcp_evt_s;

   typedef enum logic [1:0] {
      LPCP_IDLE = 2'b00,
      LPCP_FEED = 2'b01,
      LPCP_MOVE = 2'b11
   } lpcp_state_e;
endpackage : lpcp_pkg

// ==== design/lpcp_line_mem.sv ====
// line buffer memory, registered read
`timescale 1ns/1ps
`default_nettype none
module lpcp_line_mem (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      we,
   input  wire logic [lpcp_pkg::CNT_W-1:0] waddr,
   input  wire logic [15:0]               wdata,
   input  wire logic                      re,
   input  wire logic [lpcp_pkg::CNT_W-1:0] raddr,
   output logic      [15:0]               rdata
);
   import lpcp_pkg::*;
   logic [15:0] mem [0:LINE_WORDS-1];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 16'h0000;
      end else if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule : lpcp_line_mem
`default_nettype wire

// ==== design/lpcp_timer.sv ====
// mechanism motion timer, one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module lpcp_timer (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      start,
   input  wire logic [lpcp_pkg::TMR_W-1:0] load,
   output logic                           done
);
   import lpcp_pkg::*;
   logic [TMR_W-1:0] cnt_reg;
   wire              last = (cnt_reg == TMR_W'(1));

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
         done    <= 1'b0;
      end else begin
         done <= last & ~start;
         if (start) begin
            cnt_reg <= load;
         end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - TMR_W'(1);
         end
      end
   end
endmodule : lpcp_timer
`default_nettype wire

// ==== design/lpcp_top.sv ====
// line printer control port: command, status, buffer and interrupts
//
// Design decisions made here: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module lpcp_top (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic [1:0]                addr,
   input  wire logic [15:0]               wdata,
   input  wire logic                      wr,
   input  wire logic                      rd,
   input  wire logic                      wr_prot,
   output logic      [15:0]               rdata,
   output logic                           ext_reject,
   output logic                           irq,
   output logic                           irq_data,
   output logic                           irq_end_of_operation,
   output logic                           irq_alarm,
   input  wire logic                      mech_alarm_pin,
   input  wire logic                      protect_sw_pin,
   output logic      [15:0]               hammer_word,
   output logic                           hammer_valid,
   output logic                           paper_move,
   output logic      [3:0]                format_level,
   output logic                           top_of_form
);
   import lpcp_pkg::*;

   // pin synchronisers
   logic [1:0]       pin_meta_reg;
   logic [1:0]       pin_sync_reg;
   // control state
   lpcp_state_e      state_reg;
   lpcp_state_e      state_next;
   logic [2:0]       sel_reg;
   logic [2:0]       sel_next;
   logic             alarm_reg;
   logic             alarm_next;
   logic             eop_pend_reg;
   logic             eop_pend_next;
   logic             printing_reg;
   logic             tof_reg;
   logic             eject_reg;
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   logic [CNT_W-1:0] ptr_reg;
   logic [CNT_W-1:0] len_reg;
   logic             rd_pend_reg;
   logic [3:0]       evt_reg;
   logic [3:0]       evt_next;
   logic [3:0]       mask_reg;
   logic [2:0]       req_prev_reg;
   logic [15:0]      mem_rdata;
   logic             tmr_done;
   logic             tmr_start;
   logic [TMR_W-1:0] tmr_load;

   lpcp_cmd_s cmd;
   assign cmd = lpcp_cmd_s'(wdata);

   wire mech_alarm = pin_sync_reg[0];
   wire prot_sw    = pin_sync_reg[1];
   wire ready      = ~mech_alarm;
   wire busy       = (state_reg != LPCP_IDLE);
   wire full       = (count_reg == LINE_FULL);
   wire data_ok    = ~full & ~printing_reg;
   wire alarm_st   = alarm_reg | mech_alarm;

   // decode of the register port
   wire wr_data  = wr & (addr == A_DATA);
   wire wr_func  = wr & (addr == A_FUNC);
   wire wr_evt   = wr & (addr == A_EVT);
   wire wr_mask  = wr & (addr == A_MASK);
   wire unprot   = prot_sw & ~wr_prot;
   wire motion   = cmd.space | cmd.print | cmd.fmt_sel;
   // a refused word changes nothing but the reject event
   wire data_rej = wr_data & (unprot | ~data_ok);
   wire func_rej = wr_func & ((unprot & (cmd.clr_prn | cmd.space))
                   | (motion & (busy | ~ready)));
   wire acc_data = wr_data & ~data_rej;
   wire acc_func = wr_func & ~func_rej;
   wire clr_all  = acc_func & cmd.clr_prn;
   wire clr_irq  = acc_func & (cmd.clr_int | cmd.clr_prn);
   wire go_print = acc_func & cmd.print;
   wire go_move  = acc_func & (cmd.space | cmd.fmt_sel) & ~cmd.print;
   wire eject    = cmd.fmt_sel & (cmd.fmt_level == TOF_LEVEL);
   // either character of the word may be the illegal code
   wire illegal  = acc_data & ((wdata[15:8] == ILLEGAL_CHAR)
                   | (wdata[7:0] == ILLEGAL_CHAR));
   wire feed_end = (state_reg == LPCP_FEED) & (ptr_reg == len_reg);
   wire feed_rd  = (state_reg == LPCP_FEED) & (ptr_reg != len_reg);
   wire busy_end = (state_reg == LPCP_MOVE) & tmr_done;

   // clear acts first, then the selects of the same word
   assign sel_next = (sel_reg & ~{3{clr_irq}})
                     | ({cmd.alarm_sel, cmd.eop_sel, cmd.data_sel} & {3{acc_func}});
   assign alarm_next = (alarm_reg & ~clr_all) | illegal;
   // end of operation is caught on the busy edge, not as a level
   assign eop_pend_next = (eop_pend_reg & ~clr_irq)
                          | (busy_end & sel_next[SEL_EOP]);
   assign count_next = clr_all  ? '0 :
                       acc_data ? count_reg + CNT_W'(1) :
                       feed_end ? '0 : count_reg;

   // interrupt requests hold as levels
   wire req_data  = sel_reg[SEL_DATA] & data_ok;
   wire req_eop   = sel_reg[SEL_EOP] & eop_pend_reg;
   wire req_alarm = sel_reg[SEL_ALARM] & alarm_st;
   wire [2:0] req = {req_alarm, req_eop, req_data};

   // status word
   // bits 6, 8 and 10 up read as zero
   wire [15:0] status = {6'h00, tof_reg, 1'b0, prot_sw, 1'b0,
                         alarm_st, ~busy, data_ok, |req, busy, ready};

   lpcp_evt_s evt_set;
   assign evt_set.reject = data_rej | func_rej;
   assign evt_set.alarm  = req_alarm & ~req_prev_reg[SEL_ALARM];
   assign evt_set.eop    = req_eop & ~req_prev_reg[SEL_EOP];
   assign evt_set.data   = req_data & ~req_prev_reg[SEL_DATA];
   // set wins over a write-one clear in the same cycle
   assign evt_next = (evt_reg & ~(wdata[3:0] & {4{wr_evt}})) | evt_set;

   wire [15:0] rd_mux = (addr == A_DATA) ? status :
                        (addr == A_FUNC) ? {13'h0000, sel_reg} :
                        (addr == A_EVT)  ? {12'h000, evt_reg} :
                                           {12'h000, mask_reg};

   // state machine
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         LPCP_IDLE: begin
            if (go_print) begin
               state_next = LPCP_FEED;
            end else if (go_move) begin
               state_next = LPCP_MOVE;
            end
         end
         LPCP_FEED: begin
            if (feed_end) begin
               state_next = LPCP_MOVE;
            end
         end
         LPCP_MOVE: begin
            if (tmr_done) begin
               state_next = LPCP_IDLE;
            end
         end
         default: state_next = LPCP_IDLE;
      endcase
   end

   assign tmr_start = feed_end | go_move;
   // a print ends with a wait of its own length, PRINT_LD, with paper_move held low
   assign tmr_load  = feed_end ? PRINT_LD : (eject ? EJECT_LD : SPACE_LD);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pin_meta_reg <= 2'h0;
         pin_sync_reg <= 2'h0;
      end else begin
         pin_meta_reg <= {protect_sw_pin, mech_alarm_pin};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg    <= LPCP_IDLE;
         sel_reg      <= 3'h0;
         alarm_reg    <= 1'b0;
         eop_pend_reg <= 1'b0;
         count_reg    <= '0;
         req_prev_reg <= 3'h0;
      end else begin
         state_reg    <= state_next;
         sel_reg      <= sel_next;
         alarm_reg    <= alarm_next;
         eop_pend_reg <= eop_pend_next;
         count_reg    <= count_next;
         req_prev_reg <= req;
      end
   end

   // print walks the buffer from word zero up to the loaded count
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ptr_reg      <= '0;
         len_reg      <= '0;
         printing_reg <= 1'b0;
      end else if (go_print) begin
         ptr_reg      <= '0;
         len_reg      <= count_reg;
         printing_reg <= 1'b1;
      end else begin
         if (feed_rd) begin
            ptr_reg <= ptr_reg + CNT_W'(1);
         end
         if (busy_end) begin
            printing_reg <= 1'b0;
         end
      end
   end

   // only a finished eject leaves the paper at top of form
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tof_reg      <= 1'b0;
         eject_reg    <= 1'b0;
         format_level <= 4'h0;
      end else begin
         if (go_move & cmd.fmt_sel) begin
            format_level <= cmd.fmt_level;
         end
         // any other move, print included, leaves it
         if (go_move | go_print) begin
            eject_reg <= go_move & eject;
         end
         if (busy_end) begin
            tof_reg <= eject_reg;
         end
      end
   end

   assign top_of_form = tof_reg;

   // mechanism side outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rd_pend_reg  <= 1'b0;
         hammer_valid <= 1'b0;
         hammer_word  <= 16'h0000;
         paper_move   <= 1'b0;
      end else begin
         rd_pend_reg  <= feed_rd;
         hammer_valid <= rd_pend_reg;
         hammer_word  <= rd_pend_reg ? mem_rdata : hammer_word;
         paper_move   <= (state_next == LPCP_MOVE) & ~(printing_reg | go_print);
      end
   end

   // host side outputs
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata                <= 16'h0000;
         ext_reject           <= 1'b0;
         evt_reg              <= 4'h0;
         mask_reg             <= 4'h0;
         irq                  <= 1'b0;
         irq_data             <= 1'b0;
         irq_end_of_operation <= 1'b0;
         irq_alarm            <= 1'b0;
      end else begin
         rdata                <= rd ? rd_mux : 16'h0000;
         ext_reject           <= data_rej | func_rej;
         evt_reg              <= evt_next;
         mask_reg             <= wr_mask ? wdata[3:0] : mask_reg;
         // events of this cycle count, so a set shows at once
         irq                  <= |(evt_next & mask_reg);
         irq_data             <= req_data;
         irq_end_of_operation <= req_eop;
         irq_alarm            <= req_alarm;
      end
   end

   lpcp_line_mem u_mem (
      .clk   (clk),
      .rstn  (rstn),
      .we    (acc_data),
      .waddr (count_reg),
      .wdata (wdata),
      .re    (feed_rd),
      .raddr (ptr_reg),
      .rdata (mem_rdata)
   );

   lpcp_timer u_tmr (
      .clk   (clk),
      .rstn  (rstn),
      .start (tmr_start),
      .load  (tmr_load),
      .done  (tmr_done)
   );
endmodule : lpcp_top
`default_nettype wire

// ==== bench/lpcp_host.sv ====
// host channel model: master of the register port
`timescale 1ns/1ps
`default_nettype none
module lpcp_host
   import lpcp_pkg::*;
(
   input  wire logic        clk,
   input  wire logic [15:0] rdata,
   input  wire logic        ext_reject,
   output logic      [1:0]  addr,
   output logic      [15:0] wdata,
   output logic             wr,
   output logic             rd,
   output logic             wr_prot
);
   logic prot_acc = 1'b1;
   initial begin
      addr = 2'h0;
      wdata = 16'h0;
      wr = 1'b0;
      rd = 1'b0;
      wr_prot = 1'b1;
   end
   // one word per write: two characters
   task automatic wr_w(input logic [1:0] a, input logic [15:0] d, output logic rej);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_prot <= prot_acc;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
      #1 rej = ext_reject;
   endtask : wr_w
   task automatic rd_w(input logic [1:0] a, output logic [15:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_w
   // bounded poll, no next operation while busy
   task automatic wait_idle(output logic ok);
      logic [15:0] s;
      ok = 1'b0;
      for (int i = 0; i < 5000 && !ok; i++) begin
         rd_w(A_DATA, s);
         ok = (s[ST_BUSY] === 1'b0);
      end
   endtask : wait_idle
endmodule : lpcp_host
`default_nettype wire

// ==== bench/lpcp_top_assertions.sv ====
// port checker for the line printer control port
`timescale 1ns/1ps
`default_nettype none
module lpcp_chk
   import lpcp_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [1:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic        wr_prot,
   input wire logic [15:0] rdata,
   input wire logic        ext_reject,
   input wire logic        irq,
   input wire logic        irq_end_of_operation,
   input wire logic        irq_alarm,
   input wire logic        mech_alarm_pin,
   input wire logic        protect_sw_pin
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   chk_rdata_idle: assert property (!$past(rd) |-> rdata == 16'h0)
      else $error("read data not zero outside read");
   chk_reject_cause: assert property (ext_reject |-> $past(wr))
      else $error("reject without a write");
   // pins pass two flops, so four stable cycles are safe
   chk_prot_data: assert property (
      (protect_sw_pin [*4] ##0 (wr && !wr_prot && addr == A_DATA)) |=> ext_reject)
      else $error("unprotected data write not rejected");
   chk_prot_status: assert property (
      (protect_sw_pin [*4] ##0 (rd && addr == A_DATA)) |=> rdata[ST_PROT])
      else $error("protect bit missing");
   chk_mech_status: assert property (
      (mech_alarm_pin [*4] ##0 (rd && addr == A_DATA))
      |=> !rdata[ST_READY] && rdata[ST_ALARM])
      else $error("mechanism alarm not in status");
   chk_busy_flag: assert property (
      (rd && addr == A_DATA) |=> rdata[ST_BUSY] != rdata[ST_EOP])
      else $error("busy and not busy agree");
   chk_func_read: assert property ((rd && addr == A_FUNC) |=> rdata[15:3] == 13'h0)
      else $error("function readback upper bits set");
   chk_eop_clear: assert property (
      (wr && wr_prot && addr == A_FUNC && wdata[1] && wdata[7:3] == 5'h0)
      |-> ##2 !irq_end_of_operation)
      else $error("end request survives clear");
   chk_alarm_desel: assert property (
      (wr && wr_prot && addr == A_FUNC && wdata[7:4] == 4'h0 && wdata[1:0] != 2'h0)
      |-> ##2 !irq_alarm)
      else $error("alarm request survives deselect");
   chk_mask_off: assert property (
      (wr && addr == A_MASK && wdata[3:0] == 4'h0 ##1 !(wr && addr == A_MASK)) |-> ##1 !irq)
      else $error("irq high with all masked");
endmodule : lpcp_chk
bind lpcp_top lpcp_chk i_chk (
   .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .wr_prot(wr_prot), .rdata(rdata), .ext_reject(ext_reject), .irq(irq),
   .irq_end_of_operation(irq_end_of_operation), .irq_alarm(irq_alarm),
   .mech_alarm_pin(mech_alarm_pin), .protect_sw_pin(protect_sw_pin)
);
`default_nettype wire

// ==== bench/tb_lpcp_top.sv ====
// self-checking bench for the line printer control port
`timescale 1ns/1ps
`default_nettype none
module tb_lpcp_top;
   import lpcp_pkg::*;
   logic        clk, rstn, mech, psw, rej, ok, wr, rd, wr_prot;
   logic        irq, irq_d, irq_e, irq_a, rjo, hv, pm, tof;
   logic [1:0]  addr;
   logic [3:0]  fl;
   logic [15:0] wdata, rdata, hw, s, w;
   logic [15:0] q[$];
   logic [15:0] got[$];
   int          fail_count, total_checks, cyc, seed;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   lpcp_host i_host (.clk(clk), .rdata(rdata), .ext_reject(rjo), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .wr_prot(wr_prot));
   lpcp_top i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .wr_prot(wr_prot), .rdata(rdata), .ext_reject(rjo), .irq(irq), .irq_data(irq_d),
      .irq_end_of_operation(irq_e), .irq_alarm(irq_a), .mech_alarm_pin(mech),
      .protect_sw_pin(psw), .hammer_word(hw), .hammer_valid(hv), .paper_move(pm),
      .format_level(fl), .top_of_form(tof));
   always @(posedge clk) if (hv === 1'b1) got.push_back(hw);
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : check
   task automatic flag(input logic b, input logic e);
      check({15'h0, b}, {15'h0, e});
   endtask : flag
   task automatic sts(input logic [15:0] e);
      i_host.rd_w(A_DATA, s);
      check(s, e);
   endtask : sts
   task automatic fw(input logic [15:0] d);
      i_host.wr_w(A_FUNC, d, rej);
   endtask : fw
   task automatic idle;
      i_host.wait_idle(ok);
      flag(ok, 1'b1);
   endtask : idle
   task automatic w2;
      repeat (2) @(posedge clk);
      #1;
   endtask : w2
   function automatic logic exp_irq(input logic [15:0] ev, input logic [15:0] mk);
      return |(ev[3:0] & mk[3:0]);
   endfunction : exp_irq
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : results
   // sized for seven mechanism moves plus polling
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fail_count++;
         results();
      end
   end
   initial begin
      rstn = 1'b0;
      mech = 1'b0;
      psw = 1'b0;
      seed = $urandom(58);
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      sts(16'h0019);
      fw(16'h0021);
      idle;
      sts(16'h0019);
      $display("test space done");
      fw(16'h0009);
      fw(16'h0020);
      idle;
      flag(irq_e, 1'b1);
      sts(16'h001d);
      i_host.rd_w(A_EVT, s);
      flag(s[1], 1'b1);
      i_host.wr_w(A_MASK, 16'h0002, rej);
      w2;
      flag(irq, exp_irq(s, 16'h0002));
      i_host.wr_w(A_EVT, 16'h000f, rej);
      w2;
      flag(irq, 1'b0);
      i_host.wr_w(A_MASK, 16'h0000, rej);
      fw(16'h0002);
      w2;
      flag(irq_e, 1'b0);
      $display("test end interrupt done");
      fw(16'h0020);
      fw(16'h000e);
      w2;
      flag(irq_d, 1'b1);
      sts(16'h000f);
      i_host.wr_w(A_DATA, 16'h0000, rej);
      fw(16'h001a);
      w2;
      flag(irq_a, 1'b1);
      sts(16'h002f);
      fw(16'h000a);
      idle;
      flag(irq_e, 1'b1);
      sts(16'h003d);
      fw(16'h0001);
      i_host.wr_w(A_DATA, 16'h4100, rej);
      idle;
      sts(16'h0039);
      $display("test alarm chain done");
      fw(16'h0005);
      for (int i = 0; i < LINE_WORDS; i++) begin
         w = {8'($urandom_range(255, 1)), 8'($urandom_range(255, 1))};
         q.push_back(w);
         i_host.wr_w(A_DATA, w, rej);
         flag(rej, 1'b0);
      end
      w2;
      flag(irq_d, 1'b0);
      fw(16'h0002);
      sts(16'h0011);
      i_host.wr_w(A_DATA, 16'h2020, rej);
      flag(rej, 1'b1);
      got.delete();
      fw(16'h0040);
      sts(16'h0003);
      idle;
      flag(got.size() == LINE_WORDS, 1'b1);
      foreach (got[i]) check(got[i], q[i]);
      sts(16'h0019);
      got.delete();
      fw(16'h0040);
      idle;
      flag(got.size() == 0, 1'b1);
      $display("test print done");
      fw(16'h1080);
      sts(16'h000b);
      flag(pm, 1'b1);
      idle;
      sts(16'h0219);
      flag(pm, 1'b0);
      check({12'h0, fl}, {12'h0, TOF_LEVEL});
      flag(tof, 1'b1);
      fw(16'h0020);
      idle;
      sts(16'h0019);
      flag(tof, 1'b0);
      $display("test eject done");
      fw(16'h0011);
      @(posedge clk);
      mech <= 1'b1;
      repeat (4) @(posedge clk);
      sts(16'h003c);
      flag(irq_a, 1'b1);
      i_host.wr_w(A_MASK, 16'h0004, rej);
      w2;
      flag(irq, 1'b1);
      i_host.wr_w(A_MASK, 16'h0000, rej);
      w2;
      flag(irq, 1'b0);
      @(posedge clk);
      mech <= 1'b0;
      fw(16'h0001);
      $display("test mechanism alarm done");
      // unprotected data, clear and space writes refused with the switch set
      @(posedge clk);
      psw <= 1'b1;
      i_host.prot_acc = 1'b0;
      repeat (4) @(posedge clk);
      sts(16'h0099);
      fw(16'h0001);
      flag(rej, 1'b1);
      fw(16'h0020);
      flag(rej, 1'b1);
      i_host.wr_w(A_DATA, 16'h2020, rej);
      flag(rej, 1'b1);
      i_host.prot_acc = 1'b1;
      psw <= 1'b0;
      $display("test protect done");
      results();
   end
endmodule : tb_lpcp_top
`default_nettype wire
